/* src/supply_cmd.sv */
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module supply_cmd (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic [7:0]  std_cond,
  input  wire logic [7:0]  cond_a,
  input  wire logic [7:0]  cond_b,
  input  wire logic [21:0] momentary_current_query,
  input  wire logic [21:0] stored_peak_current,
  input  wire logic [21:0] stored_low_current,
  input  wire logic [21:0] analog_setpoint,
  input  wire logic        analog_mode,
  input  wire logic        power_down,
  output logic             srq,
  output logic             ist,
  output logic             bus_addressed,
  output logic      [21:0] current_setpoint
);
  localparam int W = supply_cmd_pkg::CUR_W;

  typedef struct packed {
    logic                  wait_r;
    logic [31:0]           rdata;
    logic [4:0][7:0]       mask;
    logic [7:0]            evt_std;
    logic [7:0]            event_reg_a;
    logic [7:0]            event_reg_b;
    logic [2:0][7:0]       c1;
    logic [2:0][7:0]       c2;
    logic [2:0][7:0]       cp;
    logic [3:0][W-1:0]     m1;
    logic [3:0][W-1:0]     m2;
    logic [1:0]            a1;
    logic [1:0]            a2;
    logic                  pd_prev;
    logic [W-1:0]          setpt;
    logic [W-1:0]          limit;
    logic                  psc;
    logic                  addressed;
    logic [12:0][7:0]      resp;
    logic [3:0]            resp_len;
    logic                  srq;
    logic                  ist;
    logic [W-1:0]          out_setpt;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // Rounds to nearest whole multiple of a step
  function automatic logic [W-1:0] round_step(input logic [W-1:0] v,
                                              input logic [W-1:0] st);
    logic [W:0] q;
    q = ({1'b0, v} + {2'b00, st[W-1:1]}) / {1'b0, st};
    return W'(q * {1'b0, st});
  endfunction
  // Binary to six BCD digits
  function automatic logic [23:0] bcd6(input logic [W-1:0] v);
    logic [23:0] b;
    b = 24'h00_0000;
    for (int i = W - 1; i >= 0; i--) begin
      for (int d = 0; d < 6; d++) begin
        if (b[d*4 +: 4] > 4'h4) begin
          b[d*4 +: 4] = b[d*4 +: 4] + 4'h3;
        end
      end
      b = {b[22:0], v[i]};
    end
    return b;
  endfunction
  // Register index decoded from a byte offset
  function automatic int idx_of(input logic [7:0] a,
                                input logic [7:0] base);
    return int'((a - base) >> 2);
  endfunction
  // Signed fixed-point answer with a four-letter keyword
  function automatic logic [12:0][7:0] fmt_value(input logic [31:0] kw,
                                                 input logic [W-1:0] v);
    logic [12:0][7:0] r;
    logic [23:0]      b;
    b = bcd6(W'(v / supply_cmd_pkg::DISP_DIV));
    for (int k = 0; k < 4; k++) begin
      r[k] = kw[31-8*k -: 8];
    end
    r[4] = supply_cmd_pkg::CH_SP;
    r[5] = supply_cmd_pkg::CH_PLUS;
    r[6] = supply_cmd_pkg::CH_ZERO | {4'h0, b[23:20]};
    r[7] = supply_cmd_pkg::CH_ZERO | {4'h0, b[19:16]};
    r[8] = supply_cmd_pkg::CH_DOT;
    for (int k = 0; k < 4; k++) begin
      r[9+k] = supply_cmd_pkg::CH_ZERO | {4'h0, b[15-4*k -: 4]};
    end
    return r;
  endfunction
  // Three decimal digits, rest of the answer blank
  function automatic logic [12:0][7:0] fmt_byte(input logic [7:0] v);
    logic [12:0][7:0] r;
    logic [23:0]      b;
    b = bcd6({14'h0000, v});
    for (int k = 0; k < 13; k++) begin
      r[k] = supply_cmd_pkg::CH_SP;
    end
    r[0] = supply_cmd_pkg::CH_ZERO | {4'h0, b[11:8]};
    r[1] = supply_cmd_pkg::CH_ZERO | {4'h0, b[7:4]};
    r[2] = supply_cmd_pkg::CH_ZERO | {4'h0, b[3:0]};
    return r;
  endfunction
  logic            acc;
  logic            do_wr;
  logic            do_rd;
  logic            full_be;
  logic [7:0]      stb;
  logic [2:0][7:0] rise;
  logic [2:0]      rd_clr;
  logic            exec_err;
  logic            lim_err;
  logic [W-1:0]    rnd;
  logic [3:0]      qsel;

  always_comb begin
    s_nxt    = s_r;
    acc      = (read | write) & s_r.wait_r;
    do_wr    = acc & write;
    do_rd    = acc & read;
    full_be  = byteenable == 4'hF;
    rd_clr   = 3'b000;
    exec_err = 1'b0;
    lim_err  = 1'b0;
    rnd      = '0;
    qsel     = writedata[3:0];
    stb = 8'h00;
    stb[supply_cmd_pkg::STB_STD] =
      |(s_r.evt_std & s_r.mask[supply_cmd_pkg::MASK_STD]);
    stb[supply_cmd_pkg::STB_A] =
      |(s_r.event_reg_a & s_r.mask[supply_cmd_pkg::MASK_A]);
    stb[supply_cmd_pkg::STB_B] =
      |(s_r.event_reg_b & s_r.mask[supply_cmd_pkg::MASK_B]);
    s_nxt.wait_r = 1'b1;
    // Two-stage input synchronisers
    s_nxt.c1 = {cond_b, cond_a, std_cond};
    s_nxt.c2 = s_r.c1;
    s_nxt.cp = s_r.c2;
    s_nxt.m1 = {analog_setpoint, stored_low_current,
                stored_peak_current, momentary_current_query};
    s_nxt.m2 = s_r.m1;
    s_nxt.a1 = {power_down, analog_mode};
    s_nxt.a2 = s_r.a1;
    s_nxt.pd_prev = s_r.a2[1];
    for (int e = 0; e < 3; e++) begin
      rise[e] = s_r.c2[e] & ~s_r.cp[e];
    end
    if (acc) begin
      s_nxt.wait_r = 1'b0;
    end
    if (do_rd) begin
      s_nxt.rdata = 32'h0000_0000;
      if (address < supply_cmd_pkg::OFF_EVT_STD) begin
        s_nxt.rdata[7:0] =
          s_r.mask[idx_of(address, supply_cmd_pkg::OFF_MASK_BASE)];
      end else if (address == supply_cmd_pkg::OFF_EVT_STD) begin
        s_nxt.rdata[7:0] = s_r.evt_std;
        rd_clr[0] = 1'b1;
      end else if (address == supply_cmd_pkg::OFF_EVT_A) begin
        s_nxt.rdata[7:0] = s_r.event_reg_a;
        rd_clr[1] = 1'b1;
      end else if (address == supply_cmd_pkg::OFF_EVT_B) begin
        s_nxt.rdata[7:0] = s_r.event_reg_b;
        rd_clr[2] = 1'b1;
      end else if (address == supply_cmd_pkg::OFF_SETPOINT) begin
        s_nxt.rdata[W-1:0] = s_r.setpt;
      end else if (address == supply_cmd_pkg::OFF_LIMIT) begin
        s_nxt.rdata[W-1:0] = s_r.limit;
      end else if (address == supply_cmd_pkg::OFF_RESP_LEN) begin
        s_nxt.rdata[3:0] = s_r.resp_len;
      end else if (address == supply_cmd_pkg::OFF_STATUS) begin
        s_nxt.rdata[9:0] = {s_r.addressed, s_r.a2[0], stb};
      end else if (address == supply_cmd_pkg::OFF_PSC) begin
        s_nxt.rdata[0] = s_r.psc;
      end else if (address >= supply_cmd_pkg::OFF_RESP_BASE &&
                   idx_of(address, supply_cmd_pkg::OFF_RESP_BASE)
                   < supply_cmd_pkg::RESP_CHARS) begin
        s_nxt.rdata[7:0] =
          s_r.resp[idx_of(address, supply_cmd_pkg::OFF_RESP_BASE)];
      end
    end
    if (do_wr && full_be) begin
      if (address < supply_cmd_pkg::OFF_EVT_STD) begin
        if (writedata <= supply_cmd_pkg::MASK_MAX) begin
          // Value 0 clears every bit
          s_nxt.mask[idx_of(address, supply_cmd_pkg::OFF_MASK_BASE)] =
            writedata[7:0];
        end
      end else if (address == supply_cmd_pkg::OFF_SETPOINT) begin
        rnd = round_step(writedata[W-1:0],
                         supply_cmd_pkg::SETPT_STEP);
        if (writedata[31:W] != '0 || rnd > s_r.limit) begin
          lim_err = 1'b1;
        end else begin
          s_nxt.setpt = rnd;
        end
      end else if (address == supply_cmd_pkg::OFF_LIMIT) begin
        rnd = round_step(writedata[W-1:0],
                         supply_cmd_pkg::LIMIT_STEP);
        if (writedata[31:W] != '0 || rnd < s_r.setpt ||
            rnd > supply_cmd_pkg::NOM_CURRENT) begin
          lim_err = 1'b1;
        end else begin
          s_nxt.limit = rnd;
        end
      end else if (address == supply_cmd_pkg::OFF_PSC) begin
        s_nxt.psc = writedata[0];
      end else if (address == supply_cmd_pkg::OFF_CMD) begin
        if (writedata[supply_cmd_pkg::CMD_CLS]) begin
          rd_clr = 3'b111;
        end
        if (writedata[supply_cmd_pkg::CMD_RST]) begin
          s_nxt.setpt = supply_cmd_pkg::SETPT_RESET;
          s_nxt.limit = supply_cmd_pkg::NOM_CURRENT;
        end
        if (writedata[supply_cmd_pkg::CMD_ADDR]) begin
          s_nxt.addressed = 1'b1;
        end
        if (writedata[supply_cmd_pkg::CMD_IFC]) begin
          s_nxt.addressed = 1'b0;
        end
      end else if (address == supply_cmd_pkg::OFF_QUERY &&
                   qsel <= supply_cmd_pkg::Q_LAST) begin
        s_nxt.resp_len = 4'(supply_cmd_pkg::RESP_CHARS);
        case (qsel)
          supply_cmd_pkg::Q_SETPT: s_nxt.resp =
            fmt_value(supply_cmd_pkg::KW_SETPT, s_r.setpt);
          supply_cmd_pkg::Q_LIMIT: s_nxt.resp =
            fmt_value(supply_cmd_pkg::KW_LIMIT, s_r.limit);
          supply_cmd_pkg::Q_NOW: s_nxt.resp =
            fmt_value(supply_cmd_pkg::KW_NOW, s_r.m2[0]);
          supply_cmd_pkg::Q_PEAK: s_nxt.resp =
            fmt_value(supply_cmd_pkg::KW_PEAK, s_r.m2[1]);
          supply_cmd_pkg::Q_LOW: s_nxt.resp =
            fmt_value(supply_cmd_pkg::KW_LOW, s_r.m2[2]);
          default: begin
            s_nxt.resp_len = 4'(supply_cmd_pkg::SHORT_CHARS);
            if (qsel < supply_cmd_pkg::Q_EVT0) begin
              s_nxt.resp = fmt_byte(
                s_r.mask[qsel - supply_cmd_pkg::Q_MASK0]);
            end else if (qsel == supply_cmd_pkg::Q_EVT0) begin
              s_nxt.resp = fmt_byte(s_r.evt_std);
              rd_clr[0] = 1'b1;
            end else if (qsel == supply_cmd_pkg::Q_EVT0 + 4'h1) begin
              s_nxt.resp = fmt_byte(s_r.event_reg_a);
              rd_clr[1] = 1'b1;
            end else begin
              s_nxt.resp = fmt_byte(s_r.event_reg_b);
              rd_clr[2] = 1'b1;
            end
          end
        endcase
      end
    end
    exec_err = lim_err;
    // New events win over a clear in the same cycle
    s_nxt.evt_std = (rd_clr[0] ? 8'h00 : s_r.evt_std) | rise[0] |
                    8'(exec_err) << supply_cmd_pkg::STD_EXEC_BIT;
    s_nxt.event_reg_a = (rd_clr[1] ? 8'h00 : s_r.event_reg_a) | rise[1];
    s_nxt.event_reg_b = (rd_clr[2] ? 8'h00 : s_r.event_reg_b) | rise[2] |
                        8'(lim_err) << supply_cmd_pkg::B_LIMIT_BIT;
    // Switch-off clears masks only when the flag is set
    if (s_r.a2[1] && !s_r.pd_prev && s_r.psc) begin
      s_nxt.mask = '0;
    end
    s_nxt.srq = |(stb & s_r.mask[supply_cmd_pkg::MASK_SRQ]);
    s_nxt.ist = |(stb & s_r.mask[supply_cmd_pkg::MASK_PP]);
    s_nxt.out_setpt = s_r.a2[0] ? s_r.m2[3] : s_r.setpt;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r        <= '0;
      s_r.wait_r <= 1'b1;
      s_r.limit  <= supply_cmd_pkg::NOM_CURRENT;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign readdata         = s_r.rdata;
  assign waitrequest      = s_r.wait_r;
  assign srq              = s_r.srq;
  assign ist              = s_r.ist;
  assign bus_addressed    = s_r.addressed;
  assign current_setpoint = s_r.out_setpt;
  // Helper views for the checks below
  logic wr_mask0;
  logic wr_cmd_rst;
  assign wr_mask0   = do_wr && full_be &&
                      address == supply_cmd_pkg::OFF_MASK_BASE;
  assign wr_cmd_rst = do_wr && full_be && address == supply_cmd_pkg::OFF_CMD
                      && writedata[supply_cmd_pkg::CMD_RST];
  sequence s_req;
    (read | write) && waitrequest;
  endsequence
  sequence s_ans;
    ##1 !waitrequest;
  endsequence
  property p_answer;
    @(posedge clk) disable iff (!nrst) s_req |-> s_ans;
  endproperty
  a_answer: assert property (p_answer) else $error("No answer in one cycle");
  property p_mask_stable;
    @(posedge clk) disable iff (!nrst)
      !wr_mask0 && !(s_r.a2[1] && !s_r.pd_prev) |=> $stable(s_r.mask[0]);
  endproperty
  a_mask_stable: assert property (p_mask_stable)
    else $error("Mask changed without a write");
  property p_mask_range;
    @(posedge clk) disable iff (!nrst)
      wr_mask0 && writedata > supply_cmd_pkg::MASK_MAX
      && !(s_r.a2[1] && !s_r.pd_prev) |=> $stable(s_r.mask[0]);
  endproperty
  a_mask_range: assert property (p_mask_range)
    else $error("Out of range mask value stored");
  property p_lim_low;
    @(posedge clk) disable iff (!nrst)
      do_wr && full_be && address == supply_cmd_pkg::OFF_LIMIT &&
      round_step(writedata[W-1:0], supply_cmd_pkg::LIMIT_STEP) < s_r.setpt
      |=> $stable(s_r.limit);
  endproperty
  a_lim_low: assert property (p_lim_low)
    else $error("Limit set below setpoint");
  property p_set_order;
    @(posedge clk) disable iff (!nrst) s_r.setpt <= s_r.limit;
  endproperty
  a_set_order: assert property (p_set_order)
    else $error("Setpoint above limit");
  sequence s_reject;
    lim_err;
  endsequence
  sequence s_flags;
    ##1 s_r.evt_std[supply_cmd_pkg::STD_EXEC_BIT] &&
        s_r.event_reg_b[supply_cmd_pkg::B_LIMIT_BIT];
  endsequence
  property p_flags;
    @(posedge clk) disable iff (!nrst) s_reject |-> s_flags;
  endproperty
  a_flags: assert property (p_flags)
    else $error("Rejection flags not raised");
  property p_dev_reset;
    @(posedge clk) disable iff (!nrst) wr_cmd_rst |=>
      s_r.setpt == supply_cmd_pkg::SETPT_RESET &&
      s_r.limit == supply_cmd_pkg::NOM_CURRENT;
  endproperty
  a_dev_reset: assert property (p_dev_reset)
    else $error("Device reset values wrong");
  property p_srq;
    @(posedge clk) disable iff (!nrst)
      ##1 srq == |($past(stb) & $past(s_r.mask[supply_cmd_pkg::MASK_SRQ]));
  endproperty
  a_srq: assert property (p_srq)
    else $error("Service request gating wrong");
  property p_read_clear;
    @(posedge clk) disable iff (!nrst)
      do_rd && address == supply_cmd_pkg::OFF_EVT_A |=>
      s_r.event_reg_a == $past(rise[1]);
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("Event register not cleared by read");
endmodule // supply_cmd
`default_nettype wire

/* src/supply_cmd_pkg.sv */
package supply_cmd_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_MASK_BASE  = 8'h00;
  localparam logic [7:0] OFF_EVT_STD    = 8'h14;
  localparam logic [7:0] OFF_EVT_A      = 8'h18;
  localparam logic [7:0] OFF_EVT_B      = 8'h1C;
  localparam logic [7:0] OFF_CMD        = 8'h20;
  localparam logic [7:0] OFF_SETPOINT   = 8'h24;
  localparam logic [7:0] OFF_LIMIT      = 8'h28;
  localparam logic [7:0] OFF_QUERY      = 8'h2C;
  localparam logic [7:0] OFF_RESP_LEN   = 8'h30;
  localparam logic [7:0] OFF_STATUS     = 8'h34;
  localparam logic [7:0] OFF_PSC        = 8'h38;
  localparam logic [7:0] OFF_RESP_BASE  = 8'h40;
  localparam int         NUM_MASKS      = 5;
  localparam int         RESP_CHARS     = 13;
  localparam int         SHORT_CHARS    = 3;
  // Mask indices
  localparam int         MASK_STD       = 0;
  localparam int         MASK_A         = 1;
  localparam int         MASK_B         = 2;
  localparam int         MASK_SRQ       = 3;
  localparam int         MASK_PP        = 4;
  localparam logic [31:0] MASK_MAX      = 32'h0000_00FF;
  // Command register bits
  localparam int         CMD_CLS        = 0;
  localparam int         CMD_RST        = 1;
  localparam int         CMD_IFC        = 2;
  localparam int         CMD_ADDR       = 3;
  // Event bits
  localparam int         STD_EXEC_BIT   = 4;
  localparam int         B_LIMIT_BIT    = 1;
  // Status byte bit positions
  localparam int         STB_A          = 0;
  localparam int         STB_B          = 1;
  localparam int         STB_STD        = 5;
  // Current values in units of 10 uA
  localparam int         CUR_W          = 22;
  localparam logic [CUR_W-1:0] NOM_CURRENT  = 22'h1E_8480;
  localparam logic [CUR_W-1:0] LIMIT_STEP   = 22'h00_0064;
  localparam logic [CUR_W-1:0] SETPT_STEP   = 22'h00_01F4;
  localparam logic [CUR_W-1:0] SETPT_RESET  = 22'h00_0000;
  localparam logic [CUR_W-1:0] DISP_DIV     = 22'h00_000A;
  // Query selectors
  localparam logic [3:0] Q_SETPT = 4'h0;
  localparam logic [3:0] Q_LIMIT = 4'h1;
  localparam logic [3:0] Q_NOW   = 4'h2;
  localparam logic [3:0] Q_PEAK  = 4'h3;
  localparam logic [3:0] Q_LOW   = 4'h4;
  localparam logic [3:0] Q_MASK0 = 4'h5;
  localparam logic [3:0] Q_EVT0  = 4'hA;
  localparam logic [3:0] Q_LAST  = 4'hC;
  // Response characters
  localparam logic [31:0] KW_SETPT = 32'h4353_4554;
  localparam logic [31:0] KW_LIMIT = 32'h434C_494D;
  localparam logic [31:0] KW_NOW   = 32'h434E_4F57;
  localparam logic [31:0] KW_PEAK  = 32'h434D_4158;
  localparam logic [31:0] KW_LOW   = 32'h434D_494E;
  localparam logic [7:0]  CH_SP    = 8'h20;
  localparam logic [7:0]  CH_PLUS  = 8'h2B;
  localparam logic [7:0]  CH_DOT   = 8'h2E;
  localparam logic [7:0]  CH_ZERO  = 8'h30;
endpackage

/* verif/host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input  wire logic        clk,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  output logic      [7:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  output logic      [3:0]  byteenable
);
  initial begin
    address    = 8'h00;
    read       = 1'b0;
    write      = 1'b0;
    writedata  = 32'h0000_0000;
    byteenable = 4'hF;
  end

  // One transfer, held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
    @(posedge clk);
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    read       <= ~w;
    write      <= w;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read      <= 1'b0;
    write     <= 1'b0;
    writedata <= ~d;
  endtask

  // Mask values are 8 bits wide, so only 0..255 is ever sent
  task automatic set_mask(input int i, input logic [7:0] v);
    logic [31:0] q;
    xfer(1'b1, supply_cmd_pkg::OFF_MASK_BASE + 8'(4 * i),
         {24'h00_0000, v}, 4'hF, q);
  endtask
endmodule // host_model
`default_nettype wire

/* verif/tb_status_enable_and_current_setpoint.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_status_enable_and_current_setpoint;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  address, std_cond = 8'h00, cond_a = 8'h00, cond_b = 8'h00;
  logic        read, write, waitrequest, srq, ist, bus_addressed;
  logic        analog_mode = 1'b0, power_down = 1'b0;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable;
  logic [21:0] now_i = 22'h03_9440, peak_i = 22'h04_5D38;
  logic [21:0] low_i = 22'h00_1234, an_sp = 22'h2D_C6C0, cur_sp;
  logic [31:0] q;
  int          failures = 0;
  int          cmp_count = 0;

  always #25 clk = ~clk;

  host_model i_host (.clk(clk), .readdata(readdata),
    .waitrequest(waitrequest), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable));

  supply_cmd i_dut (.clk(clk), .nrst(nrst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .std_cond(std_cond), .cond_a(cond_a),
    .cond_b(cond_b), .momentary_current_query(now_i),
    .stored_peak_current(peak_i), .stored_low_current(low_i),
    .analog_setpoint(an_sp), .analog_mode(analog_mode),
    .power_down(power_down), .srq(srq), .ist(ist),
    .bus_addressed(bus_addressed), .current_setpoint(cur_sp));

  task automatic cmpv(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, 4'hF, q);
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    i_host.xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
    cmpv(q, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic logic [7:0] ma(input int i);
    return supply_cmd_pkg::OFF_MASK_BASE + 8'(4 * i);
  endfunction

  // Query select, then length and all 13 buffer characters
  task automatic qchk(input logic [3:0] sel, input logic [31:0] kw,
                      input int v, input bit sh);
    logic [7:0] e [13];
    int u;
    u = v / 10;
    for (int i = 0; i < 13; i++) e[i] = supply_cmd_pkg::CH_SP;
    if (sh) begin
      for (int i = 0; i < 3; i++)
        e[i] = supply_cmd_pkg::CH_ZERO + 8'(v / 10 ** (2 - i) % 10);
    end else begin
      for (int i = 0; i < 4; i++) e[i] = kw[31 - 8 * i -: 8];
      e[5] = supply_cmd_pkg::CH_PLUS;
      e[8] = supply_cmd_pkg::CH_DOT;
      for (int j = 0; j < 6; j++)
        e[j < 2 ? 6 + j : 7 + j] =
          supply_cmd_pkg::CH_ZERO + 8'(u / 10 ** (5 - j) % 10);
    end
    wr(supply_cmd_pkg::OFF_QUERY, {28'h000_0000, sel});
    chk(supply_cmd_pkg::OFF_RESP_LEN, sh ? 32'h0000_0003 : 32'h0000_000D);
    for (int i = 0; i < 13; i++)
      chk(supply_cmd_pkg::OFF_RESP_BASE + 8'(4 * i), {24'h00_0000, e[i]});
  endtask

  task automatic summarize;
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    summarize;
  end

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    chk(supply_cmd_pkg::OFF_SETPOINT, 32'h0000_0000);
    chk(supply_cmd_pkg::OFF_LIMIT, {10'h000, supply_cmd_pkg::NOM_CURRENT});
    for (int i = 0; i < 5; i++) i_host.set_mask(i, 8'h90 ^ 8'(i));
    for (int i = 0; i < 5; i++) chk(ma(i), {24'h00_0000, 8'h90 ^ 8'(i)});
    i_host.xfer(1'b1, ma(0), 32'h0000_0100, 4'hF, q);
    i_host.xfer(1'b1, ma(0), 32'h0000_0011, 4'h3, q);
    chk(ma(0), 32'h0000_0090);
    i_host.set_mask(2, 8'h00);
    chk(ma(2), 32'h0000_0000);
    chk(8'hFC, 32'h0000_0000);
    // Event A bit 0 through masks to request and poll outputs
    i_host.set_mask(0, 8'h00);
    i_host.set_mask(1, 8'h01);
    i_host.set_mask(3, 8'h01);
    i_host.set_mask(4, 8'h00);
    cond_a <= 8'h01;
    cyc(6);
    cmpv({30'h0, srq, ist}, 32'h0000_0002);
    chk(supply_cmd_pkg::OFF_STATUS, 32'h0000_0001);
    i_host.set_mask(4, 8'h01);
    cyc(3);
    cmpv({31'h0, ist}, 32'h0000_0001);
    i_host.set_mask(3, 8'h00);
    cyc(3);
    cmpv({30'h0, srq, ist}, 32'h0000_0001);
    i_host.set_mask(1, 8'h00);
    cyc(3);
    cmpv({31'h0, ist}, 32'h0000_0000);
    chk(supply_cmd_pkg::OFF_EVT_A, 32'h0000_0001);
    chk(supply_cmd_pkg::OFF_EVT_A, 32'h0000_0000);
    // Clear-status empties all events, masks stay
    cond_a <= 8'h02;
    cond_b <= 8'h04;
    std_cond <= 8'h01;
    cyc(6);
    wr(supply_cmd_pkg::OFF_CMD, 32'h1 << supply_cmd_pkg::CMD_CLS);
    chk(supply_cmd_pkg::OFF_EVT_A, 32'h0000_0000);
    chk(supply_cmd_pkg::OFF_EVT_B, 32'h0000_0000);
    chk(supply_cmd_pkg::OFF_EVT_STD, 32'h0000_0000);
    chk(ma(4), 32'h0000_0001);
    // Interface clear
    wr(supply_cmd_pkg::OFF_CMD, 32'h1 << supply_cmd_pkg::CMD_ADDR);
    cyc(2);
    cmpv({31'h0, bus_addressed}, 32'h0000_0001);
    wr(supply_cmd_pkg::OFF_CMD, 32'h1 << supply_cmd_pkg::CMD_IFC);
    cyc(2);
    cmpv({31'h0, bus_addressed}, 32'h0000_0000);
    chk(ma(4), 32'h0000_0001);
    // Rounding, then rejected limit and setpoint
    wr(supply_cmd_pkg::OFF_LIMIT, 32'h0001_E24E);
    chk(supply_cmd_pkg::OFF_LIMIT, 32'h0001_E26C);
    wr(supply_cmd_pkg::OFF_SETPOINT, 32'h0000_04EC);
    chk(supply_cmd_pkg::OFF_SETPOINT, 32'h0000_05DC);
    cmpv({10'h000, cur_sp}, 32'h0000_05DC);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) wr(supply_cmd_pkg::OFF_LIMIT, 32'h0000_03E8);
      else wr(supply_cmd_pkg::OFF_SETPOINT, 32'h0001_E460);
      chk(supply_cmd_pkg::OFF_LIMIT, 32'h0001_E26C);
      chk(supply_cmd_pkg::OFF_SETPOINT, 32'h0000_05DC);
      chk(supply_cmd_pkg::OFF_EVT_B, 32'h0000_0002);
      chk(supply_cmd_pkg::OFF_EVT_STD, 32'h0000_0010);
    end
    // Query strings
    qchk(supply_cmd_pkg::Q_SETPT, supply_cmd_pkg::KW_SETPT, 1500, 0);
    qchk(supply_cmd_pkg::Q_LIMIT, supply_cmd_pkg::KW_LIMIT, 123500, 0);
    qchk(supply_cmd_pkg::Q_NOW, supply_cmd_pkg::KW_NOW, 234560, 0);
    qchk(supply_cmd_pkg::Q_PEAK, supply_cmd_pkg::KW_PEAK, 286008, 0);
    qchk(supply_cmd_pkg::Q_LOW, supply_cmd_pkg::KW_LOW, 4660, 0);
    i_host.set_mask(2, 8'hFF);
    for (int i = 0; i < 5; i++)
      qchk(supply_cmd_pkg::Q_MASK0 + 4'(i), 32'h0, i == 2 ? 255 : i / 4, 1);
    chk(ma(2), 32'h0000_00FF);
    cond_a <= 8'h06;
    cond_b <= 8'h05;
    std_cond <= 8'h03;
    cyc(6);
    for (int i = 0; i < 3; i++)
      qchk(supply_cmd_pkg::Q_EVT0 + 4'(i), 32'h0,
           i == 0 ? 2 : i == 1 ? 4 : 1, 1);
    chk(supply_cmd_pkg::OFF_EVT_A, 32'h0000_0000);
    chk(supply_cmd_pkg::OFF_EVT_B, 32'h0000_0000);
    // Analog path ignores the limit
    analog_mode <= 1'b1;
    cyc(4);
    cmpv({10'h000, cur_sp}, {10'h000, an_sp});
    analog_mode <= 1'b0;
    cyc(4);
    cmpv({10'h000, cur_sp}, 32'h0000_05DC);
    wr(supply_cmd_pkg::OFF_CMD, 32'h1 << supply_cmd_pkg::CMD_RST);
    chk(supply_cmd_pkg::OFF_SETPOINT, 32'h0000_0000);
    chk(supply_cmd_pkg::OFF_LIMIT, {10'h000, supply_cmd_pkg::NOM_CURRENT});
    // Switch-off clears masks only with the flag set
    for (int k = 0; k < 2; k++) begin
      wr(supply_cmd_pkg::OFF_PSC, 32'(k));
      power_down <= 1'b1;
      cyc(4);
      power_down <= 1'b0;
      cyc(4);
      chk(ma(2), k == 0 ? 32'h0000_00FF : 32'h0000_0000);
    end
    summarize;
  end
endmodule // tb_status_enable_and_current_setpoint
`default_nettype wire
